// ---- udb_pkg.sv ----
// Overview of operation
// - One buffer address: writes go to transmit shifter, reads come from receive latch.
// - A write loads the byte into the transmit shifter, held until shifted out or until a later write replaces it and restarts the frame.
// - Each write alone starts serial transmission of that byte.
// - A read returns the receive latch, the latest received byte.
// - Buffer is eight bits, bit 7 most significant, on both paths.
// - Transmit-done flag sets after 8th data bit, or after 9th bit in 9-bit framing, one clock after the stop bit starts.
package udb_pkg;
  localparam logic [7:0]  SERIAL_TX_RX_BUFFER_ADDR  = 8'h99;
  localparam logic [7:0]  SERIAL_TX_RX_BUFFER_RESET = 8'h00;
  localparam int          DATA_BITS                 = 8;
  localparam int          CLK_HZ                    = 50000000;
  localparam int          BAUD_DEFAULT              = 115200;
  localparam int          BIT_CYCLES_DEFAULT        = CLK_HZ / BAUD_DEFAULT;
  localparam int          SYNC_STAGES               = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } udb_sfr_req_t;

  typedef enum logic [1:0] {
    udb_idle_e,
    udb_start_e,
    udb_data_e,
    udb_stop_e
  } udb_state_t;
endpackage

// ---- udb_uart_data_buffer_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module udb_uart_data_buffer_port
  import udb_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
) (
  input  wire logic         i_mclk,
  input  wire logic         i_arst_n,
  input  wire udb_sfr_req_t i_sfr,
  input  wire logic         i_nine_bit_mode,
  input  wire logic         i_tx_ninth_bit,
  input  wire logic         i_tx_done_clr,
  input  wire logic         i_rx_done_clr,
  input  wire logic         i_rx_pin,
  output logic       [7:0]  o_sfr_rdata,
  output logic              o_tx_pin,
  output logic              o_tx_busy,
  output logic              o_tx_done_flag,
  output logic              o_rx_done_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic sel;
  logic buf_wr;
  assign sel    = (i_sfr.addr == SERIAL_TX_RX_BUFFER_ADDR);
  assign buf_wr = i_sfr.wr && sel;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit
  udb_state_t  tx_state;
  logic [8:0]  tx_shift;
  logic [3:0]  tx_bit;
  logic [31:0] tx_cnt;
  logic        tx_last;
  logic        tx_done_set;
  assign tx_last = (tx_cnt == 32'(BIT_CYCLES - 1));
  assign o_tx_busy = (tx_state != udb_idle_e);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_state    <= udb_idle_e;
      tx_shift    <= 9'h000;
      tx_bit      <= 4'h0;
      tx_cnt      <= 32'h0;
      o_tx_pin    <= 1'b1;
      tx_done_set <= 1'b0;
    end else begin
      tx_done_set <= 1'b0;
      if (buf_wr) begin
        tx_shift <= {i_tx_ninth_bit, i_sfr.wdata};
        tx_state <= udb_start_e;
        tx_cnt   <= 32'h0;
        tx_bit   <= 4'h0;
        o_tx_pin <= 1'b0;
      end else begin
        case (tx_state)
          udb_idle_e: begin
            o_tx_pin <= 1'b1;
          end
          udb_start_e: begin
            tx_cnt <= tx_last ? 32'h0 : tx_cnt + 32'h1;
            if (tx_last) begin
              tx_state <= udb_data_e;
              o_tx_pin <= tx_shift[0];
            end
          end
          udb_data_e: begin
            tx_cnt <= tx_last ? 32'h0 : tx_cnt + 32'h1;
            if (tx_last) begin
              tx_shift <= {1'b0, tx_shift[8:1]};
              tx_bit   <= tx_bit + 4'h1;
              if (tx_bit == 4'(DATA_BITS - 1) && !i_nine_bit_mode) begin
                tx_done_set <= 1'b1;
                tx_state    <= udb_stop_e;
                o_tx_pin    <= 1'b1;
              end else if (tx_bit == 4'(DATA_BITS)) begin
                tx_done_set <= 1'b1;
                tx_state    <= udb_stop_e;
                o_tx_pin    <= 1'b1;
              end else begin
                o_tx_pin <= tx_shift[1];
              end
            end
          end
          default: begin
            tx_cnt <= tx_last ? 32'h0 : tx_cnt + 32'h1;
            if (tx_last) begin
              tx_state <= udb_idle_e;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_done_flag <= 1'b0;
    end else if (tx_done_set) begin
      o_tx_done_flag <= 1'b1;
    end else if (i_tx_done_clr) begin
      o_tx_done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive
  logic        rx_s1;
  logic        rx_s2;
  udb_state_t  rx_state;
  logic [8:0]  rx_shift;
  logic [3:0]  rx_bit;
  logic [31:0] rx_cnt;
  logic [7:0]  rx_latch;
  logic        rx_done_set;
  logic [3:0]  rx_nbits;
  assign rx_nbits = i_nine_bit_mode ? 4'(DATA_BITS + 1) : 4'(DATA_BITS);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= i_rx_pin;
      rx_s2 <= rx_s1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_state    <= udb_idle_e;
      rx_shift    <= 9'h000;
      rx_bit      <= 4'h0;
      rx_cnt      <= 32'h0;
      rx_latch    <= SERIAL_TX_RX_BUFFER_RESET;
      rx_done_set <= 1'b0;
    end else begin
      rx_done_set <= 1'b0;
      case (rx_state)
        udb_idle_e: begin
          rx_cnt <= 32'h0;
          rx_bit <= 4'h0;
          if (!rx_s2) begin
            rx_state <= udb_start_e;
          end
        end
        udb_start_e: begin
          rx_cnt <= rx_cnt + 32'h1;
          if (rx_cnt == 32'(BIT_CYCLES / 2)) begin
            rx_cnt   <= 32'h0;
            rx_state <= rx_s2 ? udb_idle_e : udb_data_e;
          end
        end
        udb_data_e: begin
          rx_cnt <= rx_cnt + 32'h1;
          if (rx_cnt == 32'(BIT_CYCLES - 1)) begin
            rx_cnt   <= 32'h0;
            rx_shift <= i_nine_bit_mode ? {rx_s2, rx_shift[8:1]} : {1'b0, rx_s2, rx_shift[7:1]};
            rx_bit   <= rx_bit + 4'h1;
            if (rx_bit == rx_nbits - 4'h1) begin
              rx_state <= udb_stop_e;
            end
          end
        end
        default: begin
          rx_cnt <= rx_cnt + 32'h1;
          if (rx_cnt == 32'(BIT_CYCLES - 1)) begin
            rx_state    <= udb_idle_e;
            rx_latch    <= rx_shift[7:0];
            rx_done_set <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_done_flag <= 1'b0;
    end else if (rx_done_set) begin
      o_rx_done_flag <= 1'b1;
    end else if (i_rx_done_clr) begin
      o_rx_done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sfr_rdata <= SERIAL_TX_RX_BUFFER_RESET;
    end else if (i_sfr.rd && sel) begin
      o_sfr_rdata <= rx_latch;
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ---- udb_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module udb_sva
  import udb_pkg::*;
(
  input wire logic         i_mclk,
  input wire logic         i_arst_n,
  input wire udb_sfr_req_t i_sfr,
  input wire logic         i_tx_done_clr,
  input wire logic [7:0]   o_sfr_rdata,
  input wire logic         o_tx_pin,
  input wire logic         o_tx_busy,
  input wire logic         o_tx_done_flag
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  a_wr_starts_tx: assert property (i_sfr.wr && i_sfr.addr == 8'h99 |=>
    (!o_tx_pin && o_tx_busy)[*2]) else $error("no start");
  a_idle_high: assert property (!o_tx_busy |-> o_tx_pin) else $error("idle low");
  a_rd_quiet: assert property (!(i_sfr.rd && i_sfr.addr == 8'h99) |=>
    o_sfr_rdata == 8'h00) else $error("rdata");
  a_done_sticky: assert property (o_tx_done_flag && !i_tx_done_clr |=>
    o_tx_done_flag) else $error("flag lost");
  a_done_at_stop: assert property ($rose(o_tx_done_flag) |-> o_tx_busy) else $error("flag");
  a_frame_len: assert property ($rose(o_tx_busy) |-> ##[60:120] !o_tx_busy) else $error("len");
endmodule
bind udb_uart_data_buffer_port udb_sva u_sva (.*);
`default_nettype wire

// ---- udb_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module udb_peer (
  input  wire logic i_mclk,
  input  wire logic i_line,
  output var logic  o_line,
  output var logic [7:0] o_got,
  output var int    o_cnt
);
  initial begin
    o_line = 1'b1;
    o_cnt = 0;
    forever begin
      @(negedge i_line);
      repeat (4) @(posedge i_mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (8) @(posedge i_mclk);
        o_got[i] = i_line;
      end
      o_cnt++;
    end
  end
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(negedge i_mclk);
      o_line = i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[(i+7)%8];
      repeat (7) @(negedge i_mclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- udb_uart_data_buffer_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module udb_uart_data_buffer_port_tb;
  import udb_pkg::*;
  logic i_mclk = 0, i_arst_n = 0, nine = 0, tclr = 0, rclr = 0;
  udb_sfr_req_t i_sfr = '0;
  logic rx, tx, busy, tdone, rdone;
  logic [7:0] rdata, got;
  int cnt, n_mismatch = 0, n_compared = 0;
  always #10 i_mclk = ~i_mclk;
  udb_uart_data_buffer_port #(.BIT_CYCLES(8)) u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_sfr(i_sfr), .i_nine_bit_mode(nine), .i_tx_ninth_bit(1'b1), .i_tx_done_clr(tclr),
    .i_rx_done_clr(rclr), .i_rx_pin(rx), .o_sfr_rdata(rdata), .o_tx_pin(tx), .o_tx_busy(busy),
    .o_tx_done_flag(tdone), .o_rx_done_flag(rdone));
  udb_peer u_peer (.i_mclk(i_mclk), .i_line(tx), .o_line(rx), .o_got(got), .o_cnt(cnt));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic sfr(input logic w, input logic [7:0] d);
    @(negedge i_mclk);
    i_sfr = '{wr: w, rd: !w, addr: 8'h99, wdata: d};
    @(negedge i_mclk);
    i_sfr = '0;
  endtask
  task automatic t_tx(input logic [7:0] b, input logic n);
    int k;
    nine = n;
    k = 0;
    sfr(1, b);
    while (tdone !== 1 && k < 200) begin @(negedge i_mclk); k++; end
    chk(8'(k > 8 * (8 + n) && k < 8 * (10 + n)), 8'h01);
    while (busy !== 0 && k < 200) begin @(negedge i_mclk); k++; end
    chk(got, b);
    chk({7'h0, tdone}, 8'h01);
    tclr = 1;
    @(negedge i_mclk);
    tclr = 0;
    chk({7'h0, tdone}, 8'h00);
    $display("t_tx done");
  endtask
  task automatic t_rx;
    int k;
    k = 0;
    sfr(0, 0);
    chk(rdata, SERIAL_TX_RX_BUFFER_RESET);
    u_peer.send(8'h3c);
    while (rdone !== 1 && k < 40) begin @(negedge i_mclk); k++; end
    chk({7'h0, rdone}, 8'h01);
    sfr(0, 0);
    chk(rdata, 8'h3c);
    rclr = 1;
    @(negedge i_mclk);
    rclr = 0;
    chk({7'h0, rdone}, 8'h00);
    sfr(1, 8'h5a);
    sfr(0, 0);
    chk(rdata, 8'h3c);
    k = 0;
    while (busy !== 0 && k < 200) begin @(negedge i_mclk); k++; end
    chk(got, 8'h5a);
    tclr = 1;
    @(negedge i_mclk);
    tclr = 0;
    chk({7'h0, tdone}, 8'h00);
    $display("t_rx done");
  endtask
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_mclk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (16) @(negedge i_mclk);
    i_arst_n = 1;
    t_rx;
    t_tx(8'h81, 0);
    t_tx(8'ha5, 1);
    end_sim;
  end
endmodule
`default_nettype wire
